//--- include/optical_pulse_cfg.svh
`ifndef OPTICAL_PULSE_CFG_SVH
`define OPTICAL_PULSE_CFG_SVH
// Clock periods in ns
`define REF_CLK_NS    5
`define ADC_CLK_NS    125
// Widths
`define CNT_W         17
`define SMP_W         24
`define CIC_W         25
`define DEC_W         8
`define LPF_SH_W      4
`define BUF_WORDS     12
// Register offsets
`define OFS_CTRL      12'h000
`define OFS_PRF       12'h004
`define OFS_NL1       12'h008
`define OFS_NL2       12'h00C
`define OFS_ROUTE     12'h010
`define OFS_CUR       12'h014
`define OFS_LPF       12'h018
`define OFS_STAT      12'h01C
`define OFS_BUF       12'h800
`define OFS_BUF_LAST  12'h82C
// Control bit positions
`define CTL_RXEN      0
`define CTL_TWOCH     1
`define CTL_TWOS      2
`define CTL_HSEL      3
`define CTL_PSAVE     4
`define CTL_AFE       5
// Reset values
`define RST_CTRL      6'h00
`define RST_PRF       17'h01F40
`define RST_NL        17'h00206
`define RST_ROUTE     6'h21
`define RST_CUR       16'h0000
`define RST_LPF       4'h2
// Push-pull route mode code
`define PP_MODE       2'h2
`endif

//--- include/optical_pulse_pkg.sv
`include "optical_pulse_cfg.svh"
package optical_pulse_pkg;
  typedef enum logic [2:0] {PH_IDLE, PH_L1, PH_A1, PH_L2, PH_A2} phase_t;
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [11:0]       addr;
    logic [31:0]       wdata;
  } reg_req_t;
  typedef struct packed {
    logic [`SMP_W-1:0] sample;
    logic              valid;
  } heart_t;
  typedef struct packed {
    logic [4:0]        div;
    logic              clk8;
    phase_t            ph;
    logic [`CNT_W-1:0] phc;
    logic [`CNT_W-1:0] prf;
    logic [`CIC_W-1:0] i1, i2, i3, d1, d2, d3;
    logic [`DEC_W-1:0] dec;
    logic [`SMP_W-1:0] lpf;
    logic [`SMP_W-1:0] prev;
    logic [1:0]        slot;
    heart_t            heart;
    logic [1:0][`BUF_WORDS-1:0][31:0] mem;
    logic              wbuf;
    logic              rbuf;
    logic [3:0]        wptr;
    logic              irq;
    logic [31:0]       rdata;
    logic [5:0]        ctrl;
    logic [`CNT_W-1:0] fcp, nl1, nl2;
    logic [5:0]        route;
    logic [15:0]       cur;
    logic [`LPF_SH_W-1:0] lpf_sh;
    logic [3:0]        leds;
    logic              pd;
  } state_t;
endpackage : optical_pulse_pkg

//--- hdl/optical_pulse_sensor_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "optical_pulse_cfg.svh"
// Notes on behaviour
// - Forward an 8 MHz sampling clock to the analog front end.
// - Four-channel and two-channel modes; two-channel fires one LED only.
// - Pulse period 62.5 to 3861 SPS; LED pulse width programmable.
// - Samples in two's complement or offset binary.
// - Buffered samples are taken after the low-pass filter.
// - Heart stream selectable before or after the low-pass filter.
// - Power saving while the ADC is not converting.
// - Four separate LED pulse outputs follow the programmed timing.
// - Third-order decimator makes 24-bit samples, then low-pass filter.
// - Fill one 48-byte buffer, then the other, alternating.
// - Data-ready pulse each time a buffer fills.
// - One read window for both buffers, words at 4-byte steps.
// - Four-channel sample is four 24-bit values in three words.
// - Word packing: low bytes of next value above previous value.
// - Two-channel mode packs two LED/ambient pairs the same way.
// - Each LED current is an 8-bit code.
// - Routing drives LEDs for push-pull wiring only; other route modes light none.
// - Heart select 0 sends pre-filter data, 1 post-filter.
// - Power-save bit lowers ADC power; AFE bit (bit 5) powers AFE, receiver-enable bit runs the sequencer.
// - Channel-count bit picks four- or two-channel mode.
module optical_pulse_sensor_ctrl
  import optical_pulse_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // Register port
  input  wire reg_req_t    reg_req,
  output var  logic [31:0] reg_rdata,
  // Analog front end
  input  wire logic        mod_bit,
  output var  logic        adc_sample_clk,
  output var  logic        adc_power_down,
  output var  logic        receiver_afe_en,
  output var  logic [3:0]  led_drive,
  output var  logic [5:0]  led_route_select,
  output var  logic [15:0] led_current,
  // Sample stream and event
  output var  heart_t      heart_out,
  output var  logic        data_ready
);

  localparam int         DIV      = `ADC_CLK_NS / `REF_CLK_NS;
  localparam logic [4:0] DIV_LAST = 5'(DIV - 1);
  localparam logic [4:0] DIV_HALF = 5'(DIV / 2);

  state_t q, d;

  // ******************************
  // Helpers
  // ******************************

  // Offset binary to two's complement
  function automatic logic [`SMP_W-1:0] fmt(input logic [`SMP_W-1:0] v,
                                            input logic twos);
    fmt = twos ? {~v[`SMP_W-1], v[`SMP_W-2:0]} : v;
  endfunction : fmt

  // Pack current value above remainder of previous
  function automatic logic [31:0] pack(input logic [1:0] slot,
                                       input logic [23:0] cur,
                                       input logic [23:0] prv);
    case (slot)
      2'h1:    pack = {cur[7:0], prv};
      2'h2:    pack = {cur[15:0], prv[23:8]};
      default: pack = {cur, prv[23:16]};
    endcase
  endfunction : pack

  // ******************************
  // Next state
  // ******************************

  // All block behaviour
  always_comb begin
    logic                    tick;
    logic                    en;
    logic                    twos;
    logic                    last;
    logic [`CNT_W-1:0]       len;
    logic [`CIC_W-1:0]       c1, c2, c3;
    logic [`SMP_W-1:0]       cic, lnew, val;
    logic signed [`SMP_W+1:0] diff;
    logic [3:0]              idx;
    tick = (q.div == DIV_LAST);
    en   = q.ctrl[`CTL_RXEN];
    twos = q.ctrl[`CTL_TWOS];
    last = 1'b0;
    len  = '0;
    c1   = '0;
    c2   = '0;
    c3   = '0;
    cic  = '0;
    lnew = '0;
    val  = '0;
    diff = '0;
    idx  = 4'((reg_req.addr - `OFS_BUF) >> 2);
    d = q;
    d.irq = 1'b0;
    d.heart.valid = 1'b0;
    // Sampling clock divider
    d.div  = tick ? 5'h00 : 5'(q.div + 5'h01);
    d.clk8 = (d.div < DIV_HALF);
    // Register writes
    if (reg_req.wr) begin
      case (reg_req.addr)
        `OFS_CTRL:  d.ctrl   = reg_req.wdata[5:0];
        `OFS_PRF:   d.fcp    = reg_req.wdata[`CNT_W-1:0];
        `OFS_NL1:   d.nl1    = reg_req.wdata[`CNT_W-1:0];
        `OFS_NL2:   d.nl2    = reg_req.wdata[`CNT_W-1:0];
        `OFS_ROUTE: d.route  = reg_req.wdata[5:0];
        `OFS_CUR:   d.cur    = reg_req.wdata[15:0];
        `OFS_LPF:   d.lpf_sh = reg_req.wdata[`LPF_SH_W-1:0];
        default: ;
      endcase
    end
    // Register reads, answered next cycle
    d.rdata = 32'h0000_0000;
    if (reg_req.rd) begin
      case (reg_req.addr)
        `OFS_CTRL:  d.rdata = {26'h0, q.ctrl};
        `OFS_PRF:   d.rdata = {15'h0, q.fcp};
        `OFS_NL1:   d.rdata = {15'h0, q.nl1};
        `OFS_NL2:   d.rdata = {15'h0, q.nl2};
        `OFS_ROUTE: d.rdata = {26'h0, q.route};
        `OFS_CUR:   d.rdata = {16'h0, q.cur};
        `OFS_LPF:   d.rdata = {28'h0, q.lpf_sh};
        `OFS_STAT:  d.rdata = {20'h0, q.rbuf, q.wbuf, q.wptr, q.slot, 1'b0, q.ph};
        default: begin
          if (reg_req.addr >= `OFS_BUF && reg_req.addr <= `OFS_BUF_LAST)
            d.rdata = q.mem[q.rbuf][idx];
        end
      endcase
    end
    // Decimator, filter and pulse sequencer
    if (!en) begin
      d.ph   = PH_IDLE;
      d.phc  = '0;
      d.prf  = '0;
      d.slot = 2'h0;
      d.wptr = 4'h0;
    end else if (tick) begin
      d.i1  = q.i1 + {{(`CIC_W-1){1'b0}}, mod_bit};
      d.i2  = q.i2 + q.i1;
      d.i3  = q.i3 + q.i2;
      d.dec = `DEC_W'(q.dec + 1'b1);
      if (&q.dec) begin
        c1   = q.i3 - q.d1;
        c2   = c1 - q.d2;
        c3   = c2 - q.d3;
        d.d1 = q.i3;
        d.d2 = c1;
        d.d3 = c2;
        cic  = c3[`CIC_W-1] ? {`SMP_W{1'b1}} : c3[`SMP_W-1:0];
        diff = $signed({2'b00, cic}) - $signed({2'b00, q.lpf});
        lnew = q.lpf + `SMP_W'(diff >>> q.lpf_sh);
        d.lpf = lnew;
        d.heart.sample = fmt(q.ctrl[`CTL_HSEL] ? lnew : cic, twos);
        d.heart.valid  = 1'b1;
      end
      // Pulse period counter
      d.prf = (q.prf >= q.fcp - 1'b1) ? '0 : `CNT_W'(q.prf + 1'b1);
      d.phc = `CNT_W'(q.phc + 1'b1);
      len = (q.ph == PH_L1 || q.ph == PH_A1) ? q.nl1 : q.nl2;
      case (q.ph)
        PH_IDLE: d.phc = '0;
        PH_L1, PH_A1, PH_L2, PH_A2: begin
          if (q.phc >= len - 1'b1) begin
            last  = 1'b1;
            d.phc = '0;
            case (q.ph)
              PH_L1:   d.ph = PH_A1;
              PH_A1:   d.ph = q.ctrl[`CTL_TWOCH] ? PH_IDLE : PH_L2;
              PH_L2:   d.ph = PH_A2;
              default: d.ph = PH_IDLE;
            endcase
          end
        end
        default: d.ph = PH_IDLE;
      endcase
      if (q.prf >= q.fcp - 1'b1) begin
        d.ph  = PH_L1;
        d.phc = '0;
      end
      // Capture filtered value at phase end and pack words
      if (last) begin
        val    = fmt(q.lpf, twos);
        d.prev = val;
        d.slot = 2'(q.slot + 2'h1);
        if (q.slot != 2'h0) begin
          d.mem[q.wbuf][q.wptr] = pack(q.slot, val, q.prev);
          d.wptr = 4'(q.wptr + 4'h1);
          if (q.wptr == 4'(`BUF_WORDS - 1)) begin
            d.wptr = 4'h0;
            d.wbuf = ~q.wbuf;
            d.rbuf = q.wbuf;
            d.irq  = 1'b1;
          end
        end
      end
    end
    // LED drive from route code, push-pull only
    d.leds = 4'h0;
    if (q.route[5:4] == `PP_MODE && q.route[3:2] != q.route[1:0]) begin
      if (d.ph == PH_L1)
        d.leds[q.route[3:2]] = 1'b1;
      if (d.ph == PH_L2)
        d.leds[q.route[1:0]] = 1'b1;
    end
    // Follows the control value of this cycle, so it never lags the power-save bit
    d.pd = d.ctrl[`CTL_PSAVE] & (d.ph == PH_IDLE);
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q        <= '0;
      // Divider parked at wrap so the first sampling period is full length
      q.div    <= DIV_LAST;
      q.ctrl   <= `RST_CTRL;
      q.fcp    <= `RST_PRF;
      q.nl1    <= `RST_NL;
      q.nl2    <= `RST_NL;
      q.route  <= `RST_ROUTE;
      q.cur    <= `RST_CUR;
      q.lpf_sh <= `RST_LPF;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from state
  assign reg_rdata        = q.rdata;
  assign adc_sample_clk   = q.clk8;
  assign adc_power_down   = q.pd;
  assign receiver_afe_en  = q.ctrl[`CTL_AFE];
  assign led_drive        = q.leds;
  assign led_route_select = q.route;
  assign led_current      = q.cur;
  assign heart_out        = q.heart;
  assign data_ready       = q.irq;

  // ******************************
  // Checks
  // ******************************

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  clk_period_a: assert property ($rose(adc_sample_clk) |-> ##25 $rose(adc_sample_clk))
    else $error("sampling clock period wrong");
  two_ch_a: assert property ($changed(q.ph) && q.ph == PH_L2 |-> !$past(q.ctrl[1]))
    else $error("second LED phase in two-channel mode");
  heart_src_a: assert property (heart_out.valid && q.ctrl[3] |->
      heart_out.sample == (q.ctrl[2] ? {~q.lpf[23], q.lpf[22:0]} : q.lpf))
    else $error("heart sample not from filter");
  dec_rate_a: assert property (heart_out.valid |=> !heart_out.valid [*8])
    else $error("decimated samples too close");
  buf_fill_a: assert property (data_ready |-> $past(q.wptr) == 4'hB && q.wptr == 4'h0)
    else $error("buffer swap not after twelve words");
  ready_pulse_a: assert property (data_ready |=> !data_ready)
    else $error("data ready longer than one cycle");
  read_buf_a: assert property (data_ready |-> q.rbuf != q.wbuf)
    else $error("read buffer is the one being written");
  win_read_a: assert property (reg_req.rd && reg_req.addr == `OFS_BUF |=>
      reg_rdata == $past(q.mem[q.rbuf][0]))
    else $error("window word zero read wrong");
  power_save_a: assert property (adc_power_down |-> q.ctrl[4] && q.ph == PH_IDLE)
    else $error("power down outside idle");
  led_onehot_a: assert property ($onehot0(led_drive))
    else $error("more than one LED driven");
  led_invalid_a: assert property (q.route[3:2] == q.route[1:0] |=> led_drive == 4'h0)
    else $error("LED driven on invalid route");

  // Read data, LED phases and stream holding
  rdata_idle_a: assert property (!$past(reg_req.rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside read");
  led_phase_a: assert property (led_drive != 4'h0 |-> q.ph == PH_L1 || q.ph == PH_L2)
    else $error("LED driven outside an LED phase");
  rx_off_a: assert property (!q.ctrl[`CTL_RXEN] |=>
      q.ph == PH_IDLE && led_drive == 4'h0)
    else $error("pulses while receiver disabled");
  heart_hold_a: assert property (!heart_out.valid |-> $stable(heart_out.sample))
    else $error("heart sample changed without valid");
  wptr_range_a: assert property (q.wptr < 4'hC)
    else $error("buffer pointer past last word");

  fill_c: cover property (data_ready);
  post_lpf_c: cover property (heart_out.valid && q.ctrl[3]);
  four_ch_c: cover property (q.ph == PH_A2 && led_drive == 4'h0);
  two_ch_fill_c: cover property (data_ready && q.ctrl[`CTL_TWOCH]);
  pre_lpf_c: cover property (heart_out.valid && !q.ctrl[`CTL_HSEL]);

endmodule : optical_pulse_sensor_ctrl
`default_nettype wire

//--- bench/afe_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// Photodiode modulator stand-in
// ****
module afe_model (
  // From the controller
  input  wire logic       adc_sample_clk,
  input  wire logic [3:0] led_drive,
  // To the controller
  output var  logic       mod_bit
);
  logic [8:0] sum_q = 9'h000;
  // First-order modulator, denser while an LED is lit
  always @(posedge adc_sample_clk) begin
    sum_q <= {1'b0, sum_q[7:0]} + ((|led_drive) ? 9'h0C0 : 9'h040);
  end
  assign mod_bit = sum_q[8];
endmodule : afe_model
`default_nettype wire

//--- bench/tb_optical_pulse_sensor_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module tb_optical_pulse_sensor_ctrl
  import optical_pulse_pkg::*;
;
  // ****
  // Signals and clock
  // ****
  logic        ref_clk = 1'b0;
  logic        reset   = 1'b1;
  reg_req_t    req     = '0;
  logic [31:0] reg_rdata;
  logic        mod_bit, adc_sample_clk, adc_power_down, receiver_afe_en, data_ready;
  logic [3:0]  led_drive;
  logic [5:0]  led_route_select;
  logic [15:0] led_current;
  heart_t      heart_out;
  int          bad_count = 0;
  int          checked   = 0;
  int          cyc       = 0;
  always #2.5 ref_clk = ~ref_clk;

  optical_pulse_sensor_ctrl i_optical_pulse_sensor_ctrl (
    .ref_clk(ref_clk), .reset(reset), .reg_req(req), .reg_rdata(reg_rdata),
    .mod_bit(mod_bit), .adc_sample_clk(adc_sample_clk), .adc_power_down(adc_power_down),
    .receiver_afe_en(receiver_afe_en), .led_drive(led_drive),
    .led_route_select(led_route_select), .led_current(led_current),
    .heart_out(heart_out), .data_ready(data_ready));
  afe_model i_afe_model (
    .adc_sample_clk(adc_sample_clk), .led_drive(led_drive), .mod_bit(mod_bit));

  // ****
  // Shared tasks
  // ****
  task automatic close_out;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge ref_clk);
    req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge ref_clk);
    req.rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // Bounded wait for the buffer-full pulse, gathering lit LEDs
  task automatic wait_ready(input int lim, output int n, output logic [3:0] seen);
    n = 0;
    seen = '0;
    do begin
      @(posedge ref_clk);
      #1 n++;
      seen |= led_drive;
    end while (data_ready !== 1'b1 && n < lim);
    chk({31'h0, data_ready}, 32'h1);
  endtask : wait_ready

  // ****
  // Scenarios
  // ****
  task automatic t_reset_values;
    logic [11:0] a [8] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h018, 12'h100};
    logic [31:0] e [8] = '{32'h0, 32'h1F40, 32'h206, 32'h206, 32'h21, 32'h0, 32'h2, 32'h0};
    logic [31:0] d;
    for (int i = 0; i < 8; i++) begin
      rd(a[i], d);
      chk(d, e[i]);
    end
    chk({26'h0, led_route_select}, 32'h21);
  endtask : t_reset_values

  task automatic t_static;
    logic [31:0] d;
    wr(12'h000, 32'h30);
    @(posedge ref_clk);
    #1 chk({30'h0, adc_power_down, receiver_afe_en}, 32'h3);
    wr(12'h014, 32'h5A3C);
    wr(12'h010, 32'h2B);
    wr(12'h000, 32'h00);
    @(posedge ref_clk);
    #1 chk({14'h0, adc_power_down, receiver_afe_en, led_current}, 32'h5A3C);
    chk({26'h0, led_route_select}, 32'h2B);
    rd(12'h010, d);
    chk(d, 32'h2B);
  endtask : t_static

  task automatic t_adc_clock;
    int hi;
    hi = 0;
    @(posedge adc_sample_clk);
    repeat (25) begin
      @(posedge ref_clk);
      #1 hi += (adc_sample_clk === 1'b1);
    end
    chk(32'(hi), 32'd12);
    chk({31'h0, adc_sample_clk}, 32'h1);
  endtask : t_adc_clock

  // Period of 40 ticks, 8-tick phases; expect a fill every gap cycles
  task automatic t_run(input logic [31:0] ctl, input logic [3:0] lit, input int gap);
    logic [31:0] w [12];
    logic [31:0] d;
    logic [3:0]  seen;
    int          n;
    int          ok;
    logic [23:0] v;
    wr(12'h000, 32'h0);
    wr(12'h004, 32'd40);
    wr(12'h008, 32'd8);
    wr(12'h00C, 32'd8);
    wr(12'h000, ctl);
    rd(12'h000, d);
    chk(d, ctl);
    wait_ready(gap + 2000, n, seen);
    wait_ready(gap + 100, n, seen);
    chk(32'(n), 32'(gap));
    chk({28'h0, seen}, {28'h0, lit});
    for (int i = 0; i < 12; i++) rd(12'h800 + 12'(4 * i), w[i]);
    rd(12'h830, d);
    chk(d, 32'h0);
    // Groups whose captures share one filter value show the packing pattern
    ok = 0;
    for (int g = 0; g < 4; g++) begin
      v = w[3 * g][23:0];
      ok += int'(w[3 * g] === {v[7:0], v} && w[3 * g + 1] === {v[15:0], v[23:8]} &&
                 w[3 * g + 2] === {v, v[23:16]});
    end
    chk(32'(ok >= 2), 32'h1);
    chk(32'(w[11] != 32'h0), 32'h1);
    repeat (500) @(posedge ref_clk);
    for (int i = 0; i < 12; i++) begin
      rd(12'h800 + 12'(4 * i), d);
      chk(d, w[i]);
    end
  endtask : t_run

  task automatic t_heart;
    int n;
    n = 0;
    @(posedge heart_out.valid);
    do begin
      @(posedge ref_clk);
      #1 n++;
    end while (heart_out.valid !== 1'b1 && n < 7000);
    chk(32'(n), 32'd6400);
  endtask : t_heart

  // Invalid push-pull code lights nothing while the sequencer runs
  task automatic t_bad_route;
    logic [3:0] seen;
    seen = '0;
    wr(12'h010, 32'h2A);
    repeat (1200) begin
      @(posedge ref_clk);
      #1 seen |= led_drive;
    end
    chk({28'h0, seen}, 32'h0);
  endtask : t_bad_route

  // ****
  // Hang guard and main sequence
  // ****
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      bad_count++;
      close_out();
    end
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset_values();
    t_static();
    t_adc_clock();
    t_run(32'h21, 4'hC, 4000);
    t_heart();
    t_run(32'h2F, 4'h4, 8000);
    t_bad_route();
    close_out();
  end
endmodule : tb_optical_pulse_sensor_ctrl
`default_nettype wire
